/* File: verilog/mrx_pkg.sv */
// constants, opcodes and register map of the move/rotate/return/sleep execution block
package mrx_pkg;

   localparam int unsigned ADDR_W     = 6;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned PC_W       = 13;
   localparam int unsigned FADDR_W    = 7;
   localparam int unsigned FILE_DEPTH = 128;
   localparam int unsigned STACK_DEPTH = 8;
   localparam int unsigned STACK_PTR_W = 3;

   // byte offsets of the registers on the bus
   localparam logic [5:0] OFS_INSTR  = 6'h00;
   localparam logic [5:0] OFS_ACC    = 6'h04;
   localparam logic [5:0] OFS_STATUS = 6'h08;
   localparam logic [5:0] OFS_PC     = 6'h0C;
   localparam logic [5:0] OFS_FPTR   = 6'h10;
   localparam logic [5:0] OFS_FDATA  = 6'h14;
   localparam logic [5:0] OFS_STACK  = 6'h18;
   localparam logic [5:0] OFS_WDT    = 6'h1C;
   localparam logic [5:0] OFS_WAKE   = 6'h20;

   // instruction word fields
   localparam int unsigned OP_LSB  = 0;
   localparam int unsigned OP_MSB  = 3;
   localparam int unsigned F_LSB   = 4;
   localparam int unsigned F_MSB   = 10;
   localparam int unsigned D_BIT   = 11;
   localparam int unsigned K_LSB   = 12;
   localparam int unsigned K_MSB   = 19;
   localparam int unsigned INSTR_W = 20;

   // status register bits
   localparam int unsigned ST_C_BIT     = 0;
   localparam int unsigned ST_Z_BIT     = 2;
   localparam int unsigned ST_PD_BIT    = 3;
   localparam int unsigned ST_TO_BIT    = 4;
   localparam int unsigned ST_GIE_BIT   = 5;
   localparam int unsigned ST_SLEEP_BIT = 6;
   localparam int unsigned ST_BUSY_BIT  = 7;

   // stack and watchdog readback fields
   localparam int unsigned STK_DEPTH_LSB = 16;
   localparam int unsigned WDT_PRE_LSB   = 8;

   // reset values
   localparam logic [7:0]      ACC_RST   = 8'h00;
   localparam logic [PC_W-1:0] PC_RST    = 13'h0000;
   localparam logic            PD_N_RST  = 1'b1;
   localparam logic            TO_N_RST  = 1'b1;
   localparam logic            GIE_RST   = 1'b0;
   localparam logic [7:0]      WDT_RST   = 8'h00;

   typedef enum logic [3:0] {
      OP_NOP         = 4'h0,
      OP_MOVE        = 4'h1,
      OP_RET_IRQ     = 4'h2,
      OP_ROT_LEFT    = 4'h3,
      OP_ROT_RIGHT   = 4'h4,
      OP_RET_LITERAL = 4'h5,
      OP_RETURN      = 4'h6,
      OP_SLEEP       = 4'h7,
      OP_SKIP_ZERO   = 4'h8
   } mrx_op_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_EXEC   = 2'b01,
      ST_SECOND = 2'b10,
      ST_SLEEP  = 2'b11
   } mrx_state_t;

endpackage : mrx_pkg

/* File: verilog/mrx_return_stack.sv */
// eight-level circular hardware return stack
`timescale 1ns/1ps
module mrx_return_stack
(
   input  wire logic                                 mclk,
   input  wire logic                                 reset_n,
   input  wire logic                                 ce,
   input  wire logic                                 push,
   input  wire logic                                 pop,
   input  wire logic [mrx_pkg::PC_W-1:0]             push_data,
   output logic      [mrx_pkg::PC_W-1:0]             stack_top,
   output logic      [mrx_pkg::STACK_PTR_W:0]        depth
);
   import mrx_pkg::*;

   logic [PC_W-1:0]        stack_mem [0:STACK_DEPTH-1];
   logic [STACK_PTR_W-1:0] ptr_reg;
   logic [STACK_PTR_W:0]   depth_reg;
   logic [STACK_PTR_W-1:0] top_idx;

   // overflow wraps and overwrites the oldest entry, as a circular stack does
   assign top_idx   = ptr_reg - 3'h1;
   assign stack_top = stack_mem[top_idx];
   assign depth     = depth_reg;

   always_ff @(posedge mclk)
   begin
      if (ce && push)
         stack_mem[ptr_reg] <= push_data;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ptr_reg   <= 3'h0;
         depth_reg <= 4'h0;
      end
      else if (ce && push && !pop)
      begin
         ptr_reg <= ptr_reg + 3'h1;
         if (depth_reg != 4'(STACK_DEPTH))
            depth_reg <= depth_reg + 4'h1;
      end
      else if (ce && pop && !push)
      begin
         ptr_reg <= top_idx;
         if (depth_reg != 4'h0)
            depth_reg <= depth_reg - 4'h1;
      end
   end

endmodule : mrx_return_stack

/* File: verilog/mrx_exec_core.sv */
// execution core for move, no-op, returns, rotates through carry, skip and power-down
`timescale 1ns/1ps
module mrx_exec_core
(
   input  wire logic                          mclk,
   input  wire logic                          reset_n,
   input  wire logic                          ce,
   input  wire logic [mrx_pkg::ADDR_W-1:0]    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [mrx_pkg::DATA_W-1:0]    avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic      [mrx_pkg::DATA_W-1:0]    avs_readdata,
   output logic                               avs_waitrequest,
   output logic                               osc_halted,
   output logic                               global_irq_enable
);
   import mrx_pkg::*;

   logic [7:0]           file_mem [0:FILE_DEPTH-1];
   logic [INSTR_W-1:0]   instr_reg;
   logic [7:0]           acc_reg;
   logic                 carry_reg;
   logic                 zero_reg;
   logic                 pd_n_reg;
   logic                 to_n_reg;
   logic                 gie_reg;
   logic [PC_W-1:0]      pc_reg;
   logic [FADDR_W-1:0]   fptr_reg;
   logic [7:0]           wdt_reg;
   logic [7:0]           wdt_pre_reg;
   mrx_state_t           state_reg;
   logic                 ack_reg;
   logic [DATA_W-1:0]    rdata_reg;
   logic                 skip_nop_reg;

   mrx_op_t              op;
   logic [FADDR_W-1:0]   f_addr;
   logic                 dest_file;
   logic [7:0]           literal;
   logic [7:0]           opnd;
   logic [7:0]           alu_res;
   logic                 alu_writes;
   logic                 exec;
   logic                 stall;
   logic                 req;
   logic                 bus_wr;
   logic                 take;
   logic [DATA_W-1:0]    rd_mux;
   logic [DATA_W-1:0]    wmask;
   logic                 sleep_exec;
   logic                 pop;
   logic                 wdt_wrap;
   logic [PC_W-1:0]      stk_top;
   logic [STACK_PTR_W:0] stk_depth;

   // instruction fields
   assign op        = mrx_op_t'(instr_reg[OP_MSB:OP_LSB]);
   assign f_addr    = instr_reg[F_MSB:F_LSB];
   assign dest_file = instr_reg[D_BIT];
   assign literal   = instr_reg[K_MSB:K_LSB];
   assign opnd      = file_mem[f_addr];

   assign exec       = ce && (state_reg == ST_EXEC);
   assign sleep_exec = exec && (op == OP_SLEEP);
   assign pop        = exec && (op == OP_RETURN || op == OP_RET_IRQ || op == OP_RET_LITERAL);

   // bus slave: one wait state; held off entirely while an instruction runs
   assign req             = avs_read || avs_write;
   assign stall           = (state_reg == ST_EXEC) || (state_reg == ST_SECOND);
   assign take            = ce && req && !ack_reg && !stall;
   assign bus_wr          = ce && avs_write && ack_reg;
   assign avs_waitrequest = req && !(ack_reg && ce);
   assign avs_readdata    = rdata_reg;

   assign osc_halted        = (state_reg == ST_SLEEP);
   assign global_irq_enable = gie_reg;

   always_comb
   begin
      wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   end

   // result of the file-register operations
   always_comb
   begin
      alu_res    = opnd;
      alu_writes = 1'b0;
      unique case (op)
         OP_MOVE:
         begin
            alu_res    = opnd;
            alu_writes = 1'b1;
         end
         OP_ROT_LEFT:
         begin
            alu_res    = {opnd[6:0], carry_reg};
            alu_writes = 1'b1;
         end
         OP_ROT_RIGHT:
         begin
            alu_res    = {carry_reg, opnd[7:1]};
            alu_writes = 1'b1;
         end
         default:
         begin
            alu_res    = opnd;
            alu_writes = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      rd_mux = '0;
      unique case (avs_address)
         OFS_INSTR:  rd_mux = {12'h000, instr_reg};
         OFS_ACC:    rd_mux = {24'h000000, acc_reg};
         OFS_STATUS:
         begin
            rd_mux[ST_C_BIT]     = carry_reg;
            rd_mux[ST_Z_BIT]     = zero_reg;
            rd_mux[ST_PD_BIT]    = pd_n_reg;
            rd_mux[ST_TO_BIT]    = to_n_reg;
            rd_mux[ST_GIE_BIT]   = gie_reg;
            rd_mux[ST_SLEEP_BIT] = (state_reg == ST_SLEEP);
            rd_mux[ST_BUSY_BIT]  = stall;
         end
         OFS_PC:     rd_mux = {19'h00000, pc_reg};
         OFS_FPTR:   rd_mux = {25'h0000000, fptr_reg};
         OFS_FDATA:  rd_mux = {24'h000000, file_mem[fptr_reg]};
         OFS_STACK:
         begin
            rd_mux[PC_W-1:0]                          = stk_top;
            rd_mux[STK_DEPTH_LSB+STACK_PTR_W:STK_DEPTH_LSB] = stk_depth;
         end
         OFS_WDT:
         begin
            rd_mux[7:0]                       = wdt_reg;
            rd_mux[WDT_PRE_LSB+7:WDT_PRE_LSB] = wdt_pre_reg;
         end
         default:    rd_mux = '0;
      endcase
   end

   // bus handshake
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ack_reg   <= 1'b0;
         rdata_reg <= '0;
      end
      else if (ce)
      begin
         ack_reg <= take;
         if (take)
            rdata_reg <= rd_mux;
      end
   end

   // file register array: written by execution or through the data window
   always_ff @(posedge mclk)
   begin
      if (exec && alu_writes && dest_file)
         file_mem[f_addr] <= alu_res;
      else if (bus_wr && avs_address == OFS_FDATA && avs_byteenable[0])
         file_mem[fptr_reg] <= avs_writedata[7:0];
   end

   // sequencing; a new instruction is only accepted while idle, so none runs in power-down
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg    <= ST_IDLE;
         instr_reg    <= '0;
         skip_nop_reg <= 1'b0;
      end
      else if (ce)
      begin
         unique case (state_reg)
            ST_IDLE:
               if (bus_wr && avs_address == OFS_INSTR)
               begin
                  instr_reg <= (instr_reg & ~wmask[INSTR_W-1:0]) | (avs_writedata[INSTR_W-1:0] & wmask[INSTR_W-1:0]);
                  state_reg <= ST_EXEC;
               end
            ST_EXEC:
            begin
               skip_nop_reg <= (op == OP_SKIP_ZERO) && (opnd == 8'h00);
               if (op == OP_SLEEP)
                  state_reg <= ST_SLEEP;
               else if (op == OP_RETURN || op == OP_RET_IRQ || op == OP_RET_LITERAL)
                  state_reg <= ST_SECOND;
               else if (op == OP_SKIP_ZERO && opnd == 8'h00)
                  state_reg <= ST_SECOND;
               else
                  state_reg <= ST_IDLE;
            end
            ST_SECOND:
            begin
               skip_nop_reg <= 1'b0;
               state_reg    <= ST_IDLE;
            end
            ST_SLEEP:
               if ((bus_wr && avs_address == OFS_WAKE) || wdt_wrap)
                  state_reg <= ST_IDLE;
         endcase
      end
   end

   // program counter
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         pc_reg <= PC_RST;
      else if (ce)
      begin
         if (pop)
            pc_reg <= stk_top;
         else if (exec)
            pc_reg <= pc_reg + 13'h0001;
         else if (state_reg == ST_SECOND && skip_nop_reg)
            pc_reg <= pc_reg + 13'h0001;
         else if (bus_wr && avs_address == OFS_PC)
            pc_reg <= avs_writedata[PC_W-1:0];
      end
   end

   // accumulator and window pointer
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         acc_reg  <= ACC_RST;
         fptr_reg <= '0;
      end
      else if (ce)
      begin
         if (exec && alu_writes && !dest_file)
            acc_reg <= alu_res;
         else if (exec && op == OP_RET_LITERAL)
            acc_reg <= literal;
         else if (bus_wr && avs_address == OFS_ACC && avs_byteenable[0])
            acc_reg <= avs_writedata[7:0];
         if (bus_wr && avs_address == OFS_FPTR && avs_byteenable[0])
            fptr_reg <= avs_writedata[FADDR_W-1:0];
      end
   end

   // arithmetic flags and interrupt enable
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         carry_reg <= 1'b0;
         zero_reg  <= 1'b0;
         gie_reg   <= GIE_RST;
      end
      else if (ce)
      begin
         if (exec && op == OP_MOVE)
            zero_reg <= (opnd == 8'h00);
         else if (bus_wr && avs_address == OFS_STATUS && avs_byteenable[0])
            zero_reg <= avs_writedata[ST_Z_BIT];
         if (exec && op == OP_ROT_LEFT)
            carry_reg <= opnd[7];
         else if (exec && op == OP_ROT_RIGHT)
            carry_reg <= opnd[0];
         else if (bus_wr && avs_address == OFS_STATUS && avs_byteenable[0])
            carry_reg <= avs_writedata[ST_C_BIT];
         if (exec && op == OP_RET_IRQ)
            gie_reg <= 1'b1;
         else if (bus_wr && avs_address == OFS_STATUS && avs_byteenable[0])
            gie_reg <= avs_writedata[ST_GIE_BIT];
      end
   end

   // watchdog keeps counting in power-down, as it runs on mclk gated only by ce; a wrap there wakes the core
   assign wdt_wrap = (wdt_reg == 8'hFF) && (wdt_pre_reg == 8'hFF) && !sleep_exec;

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wdt_reg     <= WDT_RST;
         wdt_pre_reg <= WDT_RST;
      end
      else if (ce)
      begin
         if (sleep_exec)
         begin
            wdt_reg     <= 8'h00;
            wdt_pre_reg <= 8'h00;
         end
         else
         begin
            wdt_pre_reg <= wdt_pre_reg + 8'h01;
            if (wdt_pre_reg == 8'hFF)
               wdt_reg <= wdt_reg + 8'h01;
         end
      end
   end

   // power-down and timeout flags, active low
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pd_n_reg <= PD_N_RST;
         to_n_reg <= TO_N_RST;
      end
      else if (ce)
      begin
         if (sleep_exec)
         begin
            pd_n_reg <= 1'b0;
            to_n_reg <= 1'b1;
         end
         else if (wdt_wrap)
            to_n_reg <= 1'b0;
      end
   end

   mrx_return_stack u_stack
   (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .ce        (ce),
      .push      (bus_wr && avs_address == OFS_STACK),
      .pop       (pop),
      .push_data (avs_writedata[PC_W-1:0]),
      .stack_top (stk_top),
      .depth     (stk_depth)
   );

   AST_MOVE_TO_ACC: assert property (@(posedge mclk) disable iff (!reset_n)
      exec && op == OP_MOVE && !dest_file |=> acc_reg == $past(opnd))
      else $error("move to accumulator lost the value");

   AST_MOVE_FLAGS: assert property (@(posedge mclk) disable iff (!reset_n)
      exec && op == OP_MOVE |=> zero_reg == ($past(opnd) == 8'h00) && carry_reg == $past(carry_reg))
      else $error("move flag update wrong");

   AST_RET_IRQ: assert property (@(posedge mclk) disable iff (!reset_n)
      exec && op == OP_RET_IRQ |=> pc_reg == $past(stk_top) && gie_reg && zero_reg == $past(zero_reg))
      else $error("return from interrupt wrong");

   AST_ROT_LEFT: assert property (@(posedge mclk) disable iff (!reset_n)
      exec && op == OP_ROT_LEFT && !dest_file
      |=> carry_reg == $past(opnd[7]) && acc_reg == {$past(opnd[6:0]), $past(carry_reg)})
      else $error("rotate left wrong");

   AST_ROT_RIGHT: assert property (@(posedge mclk) disable iff (!reset_n)
      exec && op == OP_ROT_RIGHT
      |=> carry_reg == $past(opnd[0]) && zero_reg == $past(zero_reg) && gie_reg == $past(gie_reg))
      else $error("rotate right wrong");

   AST_RET_LITERAL: assert property (@(posedge mclk) disable iff (!reset_n)
      exec && op == OP_RET_LITERAL
      |=> acc_reg == $past(literal) && pc_reg == $past(stk_top) && state_reg == ST_SECOND)
      else $error("return with literal wrong");

   AST_RETURN: assert property (@(posedge mclk) disable iff (!reset_n)
      exec && op == OP_RETURN |=> pc_reg == $past(stk_top) && state_reg == ST_SECOND && carry_reg == $past(carry_reg))
      else $error("subroutine return wrong");

   AST_SLEEP_WDT: assert property (@(posedge mclk) disable iff (!reset_n)
      sleep_exec |=> wdt_reg == 8'h00 && wdt_pre_reg == 8'h00)
      else $error("watchdog not cleared by power-down");

   AST_SLEEP_FLAGS: assert property (@(posedge mclk) disable iff (!reset_n)
      sleep_exec |=> !pd_n_reg && to_n_reg && carry_reg == $past(carry_reg) && zero_reg == $past(zero_reg))
      else $error("power-down flags wrong");

   AST_SLEEP_HALT: assert property (@(posedge mclk) disable iff (!reset_n)
      sleep_exec |=> osc_halted)
      else $error("power-down did not halt");

   AST_NOP: assert property (@(posedge mclk) disable iff (!reset_n)
      exec && op == OP_NOP
      |=> pc_reg == $past(pc_reg) + 13'h0001 && acc_reg == $past(acc_reg) && state_reg == ST_IDLE)
      else $error("no-op changed state");

   AST_SKIP: assert property (@(posedge mclk) disable iff (!reset_n)
      exec && op == OP_SKIP_ZERO && opnd == 8'h00 && pc_reg != 13'h1FFF
      |=> state_reg == ST_SECOND ##1 (!$past(ce) || pc_reg == $past(pc_reg, 2) + 13'h0002))
      else $error("zero skip did not cost two cycles");

endmodule : mrx_exec_core

/* File: tb/mrx_testbench.sv */
// self-checking bench for the move, rotate, return and power-down execution core
`timescale 1ns/1ps
module testbench;
   import mrx_pkg::*;
   logic        mclk          = 1'b0;
   logic        reset_n       = 1'b0;
   logic        ce            = 1'b1;
   logic [5:0]  avs_address   = 6'h00;
   logic        avs_read      = 1'b0;
   logic        avs_write     = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        osc_halted;
   logic        global_irq_enable;
   logic [31:0] rd;
   int          n_mismatch    = 0;
   int          n_compared    = 0;
   int          cyc           = 0;

   always #20 mclk = ~mclk;

   mrx_exec_core u_mrx_exec_core (.mclk(mclk), .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .osc_halted(osc_halted),
      .global_irq_enable(global_irq_enable));

   task automatic tally_and_finish;
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one idle edge first so a release and the next request never share a time step
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      // read right at the edge, before that edge's updates land, so we see what the slave sampled
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic rchk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rchk

   task automatic ex(input logic [3:0] op, input logic [6:0] f, input logic d, input logic [7:0] k);
      bus(1'b1, OFS_INSTR, {12'h000, k, d, f, op});
   endtask : ex

   task automatic setf(input logic [6:0] f, input logic [7:0] v);
      bus(1'b1, OFS_FPTR, {25'h0, f});
      bus(1'b1, OFS_FDATA, {24'h0, v});
   endtask : setf

   task automatic t_move;
      bus(1'b1, OFS_STATUS, 32'h01);
      setf(7'h7F, 8'h00);
      bus(1'b1, OFS_ACC, 32'h55);
      ex(OP_MOVE, 7'h7F, 1'b0, 8'h00);
      rchk(OFS_ACC, 32'h00);
      rchk(OFS_STATUS, 32'h1D);
      setf(7'h7F, 8'h80);
      ex(OP_MOVE, 7'h7F, 1'b1, 8'h00);
      rchk(OFS_ACC, 32'h00);
      rchk(OFS_FDATA, 32'h80);
      rchk(OFS_STATUS, 32'h19);
   endtask : t_move

   task automatic t_rot;
      setf(7'h05, 8'h81);
      ex(OP_ROT_LEFT, 7'h05, 1'b1, 8'h00);
      rchk(OFS_FDATA, 32'h03);
      rchk(OFS_STATUS, 32'h19);
      bus(1'b1, OFS_STATUS, 32'h04);
      ex(OP_ROT_LEFT, 7'h05, 1'b0, 8'h00);
      rchk(OFS_ACC, 32'h06);
      rchk(OFS_STATUS, 32'h1C);
      ex(OP_ROT_RIGHT, 7'h05, 1'b0, 8'h00);
      rchk(OFS_ACC, 32'h01);
      rchk(OFS_FDATA, 32'h03);
      rchk(OFS_STATUS, 32'h1D);
      ex(OP_ROT_RIGHT, 7'h05, 1'b1, 8'h00);
      rchk(OFS_FDATA, 32'h81);
      rchk(OFS_ACC, 32'h01);
   endtask : t_rot

   task automatic t_ret;
      bus(1'b1, OFS_STATUS, 32'h00);
      bus(1'b1, OFS_STACK, 32'h0011);
      bus(1'b1, OFS_STACK, 32'h1ABC);
      ex(OP_RETURN, 7'h00, 1'b0, 8'h00);
      rchk(OFS_PC, 32'h1ABC);
      ex(OP_RETURN, 7'h00, 1'b0, 8'h00);
      rchk(OFS_PC, 32'h0011);
      rchk(OFS_STATUS, 32'h18);
      bus(1'b1, OFS_STACK, 32'h0123);
      ex(OP_RET_LITERAL, 7'h00, 1'b0, 8'hFF);
      rchk(OFS_ACC, 32'hFF);
      rchk(OFS_PC, 32'h0123);
      rchk(OFS_STATUS, 32'h18);
      bus(1'b1, OFS_STACK, 32'h0042);
      chk({31'h0, global_irq_enable}, 32'h0);
      ex(OP_RET_IRQ, 7'h00, 1'b0, 8'h00);
      rchk(OFS_PC, 32'h0042);
      chk({31'h0, global_irq_enable}, 32'h1);
      rchk(OFS_STATUS, 32'h38);
   endtask : t_ret

   task automatic t_nop_skip;
      bus(1'b1, OFS_PC, 32'h10);
      ex(OP_NOP, 7'h00, 1'b0, 8'h00);
      rchk(OFS_PC, 32'h11);
      rchk(OFS_ACC, 32'hFF);
      rchk(OFS_STATUS, 32'h38);
      setf(7'h09, 8'h00);
      ex(OP_SKIP_ZERO, 7'h09, 1'b0, 8'h00);
      rchk(OFS_PC, 32'h13);
      setf(7'h09, 8'h01);
      ex(OP_SKIP_ZERO, 7'h09, 1'b0, 8'h00);
      rchk(OFS_PC, 32'h14);
   endtask : t_nop_skip

   // the watchdog keeps counting in power-down, so only a small prescaler is allowed
   task automatic t_sleep;
      ex(OP_SLEEP, 7'h00, 1'b0, 8'h00);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h7F, 32'h70);
      chk({31'h0, osc_halted}, 32'h1);
      bus(1'b0, OFS_WDT, 32'h0);
      chk({24'h0, rd[7:0]}, 32'h0);
      chk({31'h0, rd[15:8] < 8'h10}, 32'h1);
      ex(OP_NOP, 7'h00, 1'b0, 8'h00);
      rchk(OFS_PC, 32'h15);
      bus(1'b1, OFS_WAKE, 32'h0);
      // the wake lands at the edge the bus task returns on, so look one edge later
      @(posedge mclk);
      chk({31'h0, osc_halted}, 32'h0);
   endtask : t_sleep

   // with the enable low for 100 cycles the watchdog prescaler must stand still
   task automatic t_freeze;
      logic [7:0] p;
      bus(1'b0, OFS_WDT, 32'h0);
      p = rd[15:8];
      @(posedge mclk);
      ce <= 1'b0;
      repeat (100) @(posedge mclk);
      ce <= 1'b1;
      bus(1'b0, OFS_WDT, 32'h0);
      chk({31'h0, (rd[15:8] - p) < 8'h20}, 32'h1);
   endtask : t_freeze

   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      rchk(OFS_STATUS, 32'h18);
      t_move();
      t_rot();
      t_ret();
      t_nop_skip();
      t_freeze();
      t_sleep();
      tally_and_finish();
   end
endmodule : testbench
